/* hw/sdcs_pkg.sv */
// package: register map, card status layout, command codes, shared functions
package sdcs_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_ARG = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_CSTAT = 8'h0c;
  localparam logic [7:0] OFF_DEC = 8'h10;
  localparam logic [7:0] OFF_MODE = 8'h14;
  localparam logic [7:0] OFF_SUSP = 8'h18;
  localparam logic [7:0] OFF_SDBW = 8'h1c;
  localparam logic [7:0] OFF_SDPROT = 8'h20;
  localparam logic [7:0] OFF_RCA = 8'h24;

  // command register fields
  localparam int CMDF_IDX_HI = 5;
  localparam int CMDF_APP = 6;
  localparam int CMDF_RESP = 7;
  localparam int CMDF_GO = 8;

  // status register bits (flags 1..3 and 4 are write-one-to-clear)
  localparam int STB_BUSY = 0;
  localparam int STB_CRC = 1;
  localparam int STB_REFUSED = 2;
  localparam int STB_TIMEOUT = 3;
  localparam int STB_IRQ = 4;
  localparam int STB_SLOW = 5;
  localparam int STB_SDVALID = 6;
  localparam int STB_RWAIT = 7;

  // mode register bits
  localparam int MDB_WIDE = 0;
  localparam int MDB_RWCAP = 1;
  localparam int MDB_RWREQ = 2;
  localparam int MDB_IRQEN = 3;
  localparam int MDB_FAST = 4;

  // suspend register fields
  localparam int SPF_FN_HI = 2;
  localparam int SPF_MEM = 3;
  localparam int SPF_SUSP = 4;
  localparam int SPF_RES = 5;
  localparam logic [3:0] OWNER_MEM = 4'h8;

  // card status word layout
  localparam int CS_ERROR = 19;
  localparam int CS_UNDERRUN = 18;
  localparam int CS_OVERRUN = 17;
  localparam int CS_WPSKIP = 15;
  localparam int CS_ECCOFF = 14;
  localparam int CS_ERASERST = 13;
  localparam int CS_STATE_HI = 12;
  localparam int CS_STATE_LO = 9;
  localparam int CS_READY = 8;
  localparam int CS_APP = 5;
  localparam logic [31:0] CS_ERR_MASK = 32'hfdff_0000;

  localparam logic [3:0] ST_IDLE = 4'h0;
  localparam logic [3:0] ST_READY = 4'h1;
  localparam logic [3:0] ST_IDENT = 4'h2;
  localparam logic [3:0] ST_STBY = 4'h3;
  localparam logic [3:0] ST_TRAN = 4'h4;
  localparam logic [3:0] ST_DATA = 4'h5;
  localparam logic [3:0] ST_RCV = 4'h6;
  localparam logic [3:0] ST_PRG = 4'h7;
  localparam logic [3:0] ST_DIS = 4'h8;

  // SD status: only the top 64 bits are kept
  localparam int SDS_BITS = 512;
  localparam int SDS_KEEP = 64;
  localparam int SDS_CRC_BITS = 16;
  localparam logic [1:0] SDS_BW_1 = 2'b00;
  localparam logic [1:0] SDS_BW_4 = 2'b10;

  // command frame and response timing
  localparam int FRAME_BITS = 48;
  localparam logic [7:0] RESP_WAIT_CLKS = 8'h40;

  localparam logic [5:0] CMD_GO_IDLE = 6'h00;
  localparam logic [5:0] CMD_SEND_OP = 6'h01;
  localparam logic [5:0] CMD_ALL_CID = 6'h02;
  localparam logic [5:0] CMD_SET_RCA = 6'h03;
  localparam logic [5:0] CMD_IO_OP = 6'h05;
  localparam logic [5:0] CMD_SDSTAT = 6'h0d;
  localparam logic [5:0] CMD_RD_SINGLE = 6'h11;
  localparam logic [5:0] CMD_RD_MULTI = 6'h12;
  localparam logic [5:0] CMD_WR_SINGLE = 6'h18;
  localparam logic [5:0] CMD_WR_MULTI = 6'h19;
  localparam logic [5:0] CMD_IRQ_MODE = 6'h28;
  localparam logic [5:0] CMD_OP_COND = 6'h29;
  localparam logic [5:0] CMD_IO_DATA = 6'h35;
  localparam logic [5:0] CMD_APP = 6'h37;
  localparam logic [5:0] CMD_GEN = 6'h38;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_SEND = 5'b00010,
    S_RESP = 5'b00100,
    S_BUSY = 5'b01000,
    S_DATA = 5'b10000
  } sdcs_fsm_e;

  typedef struct packed {
    logic clk;
    logic cmd;
    logic [3:0] dat;
  } sdcs_pins_s;

  typedef struct packed {
    logic [5:0] index;
    logic app;
    logic resp;
  } sdcs_cmd_s;

  function automatic logic [6:0] sdcs_crc7(input logic [39:0] d);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ 7'h09;
      end
    end
    return c;
  endfunction

  function automatic logic [47:0] sdcs_frame(input logic [5:0] idx,
                                            input logic [31:0] arg);
    return {2'b01, idx, arg, sdcs_crc7({2'b01, idx, arg}), 1'b1};
  endfunction

  // identification commands run open-drain on the slow clock
  function automatic logic sdcs_is_ident(input logic [5:0] idx,
                                         input logic app);
    return (idx == CMD_GO_IDLE) || (idx == CMD_SEND_OP) ||
           (idx == CMD_ALL_CID) || (idx == CMD_SET_RCA) ||
           (idx == CMD_IO_OP) || (idx == CMD_IRQ_MODE) ||
           (app && idx == CMD_OP_COND);
  endfunction

endpackage

/* hw/sdcs_resp_rx.sv */
// module: receives one 48-bit response frame on the command line
`timescale 1ns/1ps
module sdcs_resp_rx (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic rise,
  input wire logic cmdBit,
  output logic done,
  output logic timeout,
  output logic crcOk,
  output logic [31:0] status
);

  typedef struct packed {
    logic busy;
    logic going;
    logic [5:0] cnt;
    logic [7:0] waitCnt;
    logic [46:0] sh;
    logic done;
    logic timeout;
    logic crcOk;
    logic [31:0] status;
  } sdcs_rrx_s;

  sdcs_rrx_s r, next_r;

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.timeout = 1'b0;
    if (start) begin
      next_r.busy = 1'b1;
      next_r.going = 1'b0;
      next_r.cnt = 6'h01;
      next_r.waitCnt = 8'h00;
    end else if (r.busy && rise) begin
      if (!r.going) begin
        if (!cmdBit) begin
          next_r.going = 1'b1;
        end else if (r.waitCnt == sdcs_pkg::RESP_WAIT_CLKS) begin
          next_r.busy = 1'b0;
          next_r.timeout = 1'b1;
        end else begin
          next_r.waitCnt = r.waitCnt + 8'h01;
        end
      end else begin
        next_r.sh = {r.sh[45:0], cmdBit};
        next_r.cnt = r.cnt + 6'h01;
        if (r.cnt == 6'(sdcs_pkg::FRAME_BITS - 1)) begin
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
          next_r.status = next_r.sh[39:8];
          next_r.crcOk = next_r.sh[0] &&
            (sdcs_pkg::sdcs_crc7({1'b0, next_r.sh[46:8]}) ==
             next_r.sh[7:1]);
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign done = r.done;
  assign timeout = r.timeout;
  assign crcOk = r.crcOk;
  assign status = r.status;

endmodule

/* hw/sdcs_sdstat_rx.sv */
// module: receives the SD status block and keeps its top 64 bits
`timescale 1ns/1ps
module sdcs_sdstat_rx (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic rise,
  input wire logic wide,
  input wire logic [3:0] dat,
  output logic done,
  output logic [63:0] top
);

  typedef struct packed {
    logic busy;
    logic going;
    logic [9:0] cnt;
    logic [63:0] top;
    logic done;
  } sdcs_srx_s;

  sdcs_srx_s r, next_r;
  logic [9:0] dataClks;
  logic [9:0] keepClks;

  // clocks per block: 512 bits on one line or 128 nibbles on four
  always_comb begin
    dataClks = wide ? 10'(sdcs_pkg::SDS_BITS / 4) : 10'(sdcs_pkg::SDS_BITS);
    keepClks = wide ? 10'(sdcs_pkg::SDS_KEEP / 4) : 10'(sdcs_pkg::SDS_KEEP);
  end

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (start) begin
      next_r.busy = 1'b1;
      next_r.going = 1'b0;
      next_r.cnt = 10'h000;
    end else if (r.busy && rise) begin
      if (!r.going) begin
        next_r.going = !dat[0];
      end else begin
        if (r.cnt < keepClks) begin
          next_r.top = wide ? {r.top[59:0], dat} : {r.top[62:0], dat[0]};
        end
        next_r.cnt = r.cnt + 10'h001;
        if (r.cnt == dataClks + 10'(sdcs_pkg::SDS_CRC_BITS)) begin
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign done = r.done;
  assign top = r.top;

endmodule

/* hw/sdcs_host.sv */
// module: card command sequencer, status decoder and APB register file
`timescale 1ns/1ps
module sdcs_host (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cardClk,
  input wire logic cmdIn,
  output logic cmdOut,
  output logic cmdOe,
  input wire logic [3:0] datIn,
  output logic dat2Out,
  output logic dat2Oe,
  output logic slowClk,
  output logic openDrain
);

  typedef struct packed {
    sdcs_pkg::sdcs_pins_s sync1;
    sdcs_pkg::sdcs_pins_s sync2;
    logic clkPrev;
    sdcs_pkg::sdcs_fsm_e fsm;
    logic [5:0] bitCnt;
    logic [47:0] shift;
    logic cmdOut;
    logic cmdOe;
    sdcs_pkg::sdcs_cmd_s cmd;
    logic [31:0] arg;
    logic phase2;
    logic rxStart;
    logic sdStart;
    logic [31:0] cardStatus;
    logic crcErr;
    logic refused;
    logic timeout;
    logic irqFlag;
    logic sdValid;
    logic [63:0] sdTop;
    logic wide;
    logic rwCap;
    logic rwReq;
    logic irqEn;
    logic fastEn;
    logic [15:0] rca;
    logic [7:0] suspended;
    logic [3:0] owner;
    logic slow;
    logic od;
    logic dat2Oe;
    logic [31:0] prdata;
  } sdcs_host_s;

  sdcs_host_s r, next_r;
  logic rise, fall, wr, rdSetup, mapped, irqPeriod;
  logic respDone, respTimeout, respCrcOk, sdDone;
  logic [31:0] respStatus;
  logic [63:0] sdTop;
  logic [3:0] curState;
  logic [2:0] spFn;
  logic [2:0] spBit;
  logic [31:0] rdVal;

  sdcs_resp_rx uResp (
    .mclk(mclk),
    .reset_n(reset_n),
    .start(r.rxStart),
    .rise(rise),
    .cmdBit(r.sync2.cmd),
    .done(respDone),
    .timeout(respTimeout),
    .crcOk(respCrcOk),
    .status(respStatus)
  );

  sdcs_sdstat_rx uSdStat (
    .mclk(mclk),
    .reset_n(reset_n),
    .start(r.sdStart),
    .rise(rise),
    .wide(r.wide),
    .dat(r.sync2.dat),
    .done(sdDone),
    .top(sdTop)
  );

  always_comb begin
    rise = r.sync2.clk & ~r.clkPrev;
    fall = ~r.sync2.clk & r.clkPrev;
    wr = psel & penable & pwrite;
    rdSetup = psel & ~penable & ~pwrite;
    mapped = (paddr[1:0] == 2'b00) && (paddr <= sdcs_pkg::OFF_RCA);
    curState = r.cardStatus[sdcs_pkg::CS_STATE_HI:sdcs_pkg::CS_STATE_LO];
    // only an idle command path counts as the interrupt period
    irqPeriod = (r.fsm == sdcs_pkg::S_IDLE);
    spFn = pwdata[sdcs_pkg::SPF_FN_HI:0];
    spBit = pwdata[sdcs_pkg::SPF_MEM] ? 3'h0 : spFn;
  end

  // register read view
  always_comb begin
    rdVal = 32'h0000_0000;
    case (paddr)
      sdcs_pkg::OFF_CMD: begin
        rdVal = {24'h00_0000, r.cmd.resp, r.cmd.app, r.cmd.index};
      end
      sdcs_pkg::OFF_ARG: begin
        rdVal = r.arg;
      end
      sdcs_pkg::OFF_STAT: begin
        rdVal[sdcs_pkg::STB_BUSY] = (r.fsm != sdcs_pkg::S_IDLE);
        rdVal[sdcs_pkg::STB_CRC] = r.crcErr;
        rdVal[sdcs_pkg::STB_REFUSED] = r.refused;
        rdVal[sdcs_pkg::STB_TIMEOUT] = r.timeout;
        rdVal[sdcs_pkg::STB_IRQ] = r.irqFlag;
        rdVal[sdcs_pkg::STB_SLOW] = r.slow;
        rdVal[sdcs_pkg::STB_SDVALID] = r.sdValid;
        rdVal[sdcs_pkg::STB_RWAIT] = r.dat2Oe;
      end
      sdcs_pkg::OFF_CSTAT: begin
        rdVal = r.cardStatus;
      end
      sdcs_pkg::OFF_DEC: begin
        rdVal[3:0] = curState;
        rdVal[4] = |(r.cardStatus & sdcs_pkg::CS_ERR_MASK);
        rdVal[5] = r.cardStatus[sdcs_pkg::CS_ERROR];
        rdVal[6] = r.cardStatus[sdcs_pkg::CS_UNDERRUN];
        rdVal[7] = r.cardStatus[sdcs_pkg::CS_OVERRUN];
        rdVal[8] = r.cardStatus[sdcs_pkg::CS_WPSKIP];
        rdVal[9] = r.cardStatus[sdcs_pkg::CS_ECCOFF];
        rdVal[10] = r.cardStatus[sdcs_pkg::CS_ERASERST];
        rdVal[11] = r.cardStatus[sdcs_pkg::CS_READY];
        rdVal[12] = r.cardStatus[sdcs_pkg::CS_APP];
        rdVal[13] = curState > sdcs_pkg::ST_DIS;
      end
      sdcs_pkg::OFF_MODE: begin
        rdVal[sdcs_pkg::MDB_WIDE] = r.wide;
        rdVal[sdcs_pkg::MDB_RWCAP] = r.rwCap;
        rdVal[sdcs_pkg::MDB_RWREQ] = r.rwReq;
        rdVal[sdcs_pkg::MDB_IRQEN] = r.irqEn;
        rdVal[sdcs_pkg::MDB_FAST] = r.fastEn;
      end
      sdcs_pkg::OFF_SUSP: begin
        rdVal = {20'h0_0000, r.owner, r.suspended};
      end
      sdcs_pkg::OFF_SDBW: begin
        rdVal[1:0] = r.sdTop[63:62];
        rdVal[2] = (r.sdTop[47:32] == 16'h0000);
        rdVal[3] = (r.sdTop[63:62] == sdcs_pkg::SDS_BW_1) ||
                   (r.sdTop[63:62] == sdcs_pkg::SDS_BW_4);
      end
      sdcs_pkg::OFF_SDPROT: begin
        rdVal = r.sdTop[31:0];
      end
      sdcs_pkg::OFF_RCA: begin
        rdVal = {r.rca, 16'h0000};
      end
      default: begin
        rdVal = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    next_r = r;
    next_r.sync1 = '{clk: cardClk, cmd: cmdIn, dat: datIn};
    next_r.sync2 = r.sync1;
    next_r.clkPrev = r.sync2.clk;
    next_r.rxStart = 1'b0;
    next_r.sdStart = 1'b0;
    if (rdSetup) begin
      next_r.prdata = rdVal;
    end

    // software writes; hardware sets below override these clears
    if (wr) begin
      case (paddr)
        sdcs_pkg::OFF_ARG: begin
          next_r.arg = pwdata;
        end
        sdcs_pkg::OFF_STAT: begin
          if (pwdata[sdcs_pkg::STB_CRC]) next_r.crcErr = 1'b0;
          if (pwdata[sdcs_pkg::STB_REFUSED]) next_r.refused = 1'b0;
          if (pwdata[sdcs_pkg::STB_TIMEOUT]) next_r.timeout = 1'b0;
          if (pwdata[sdcs_pkg::STB_IRQ]) next_r.irqFlag = 1'b0;
        end
        sdcs_pkg::OFF_MODE: begin
          next_r.wide = pwdata[sdcs_pkg::MDB_WIDE];
          next_r.rwCap = pwdata[sdcs_pkg::MDB_RWCAP];
          next_r.rwReq = pwdata[sdcs_pkg::MDB_RWREQ];
          next_r.irqEn = pwdata[sdcs_pkg::MDB_IRQEN];
          next_r.fastEn = pwdata[sdcs_pkg::MDB_FAST];
        end
        sdcs_pkg::OFF_RCA: begin
          next_r.rca = pwdata[31:16];
        end
        sdcs_pkg::OFF_SUSP: begin
          if (!pwdata[sdcs_pkg::SPF_MEM] && spFn == 3'h0) begin
            next_r.refused = 1'b1;
          end else if (pwdata[sdcs_pkg::SPF_SUSP]) begin
            if (r.owner != {pwdata[sdcs_pkg::SPF_MEM], spFn}) begin
              next_r.refused = 1'b1;
            end else begin
              next_r.suspended[spBit] = 1'b1;
              next_r.owner = 4'h0;
            end
          end else if (pwdata[sdcs_pkg::SPF_RES]) begin
            if (!r.suspended[spBit] || r.owner != 4'h0) begin
              next_r.refused = 1'b1;
            end else begin
              next_r.suspended[spBit] = 1'b0;
              next_r.owner = {pwdata[sdcs_pkg::SPF_MEM], spFn};
            end
          end
        end
        sdcs_pkg::OFF_CMD: begin
          if (pwdata[sdcs_pkg::CMDF_GO]) begin
            next_r.cmd.index = pwdata[sdcs_pkg::CMDF_IDX_HI:0];
            next_r.cmd.app = pwdata[sdcs_pkg::CMDF_APP];
            next_r.cmd.resp = pwdata[sdcs_pkg::CMDF_RESP];
            if (r.fsm != sdcs_pkg::S_IDLE) begin
              next_r.refused = 1'b1;
            end else if ((pwdata[sdcs_pkg::CMDF_IDX_HI:0] ==
                          sdcs_pkg::CMD_GEN ||
                          (pwdata[sdcs_pkg::CMDF_APP] &&
                           pwdata[sdcs_pkg::CMDF_IDX_HI:0] ==
                           sdcs_pkg::CMD_SDSTAT)) &&
                         curState != sdcs_pkg::ST_TRAN) begin
              next_r.refused = 1'b1;
            end else begin
              next_r.od = sdcs_pkg::sdcs_is_ident(
                pwdata[sdcs_pkg::CMDF_IDX_HI:0], pwdata[sdcs_pkg::CMDF_APP]);
              next_r.slow = next_r.od | ~r.fastEn;
              next_r.phase2 = ~pwdata[sdcs_pkg::CMDF_APP];
              next_r.shift = pwdata[sdcs_pkg::CMDF_APP] ?
                sdcs_pkg::sdcs_frame(sdcs_pkg::CMD_APP, {r.rca, 16'h0000}) :
                sdcs_pkg::sdcs_frame(pwdata[sdcs_pkg::CMDF_IDX_HI:0], r.arg);
              next_r.bitCnt = 6'h00;
              next_r.fsm = sdcs_pkg::S_SEND;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // sticky interrupt: set wins over a same-cycle clear
    if (r.irqEn && irqPeriod && rise && !r.sync2.dat[1]) begin
      next_r.irqFlag = 1'b1;
    end
    // read wait holds data line 2 low only between transfers
    next_r.dat2Oe = r.rwCap & r.rwReq & irqPeriod;

    case (r.fsm)
      sdcs_pkg::S_IDLE: begin
        next_r.cmdOe = 1'b0;
        next_r.cmdOut = 1'b1;
      end
      sdcs_pkg::S_SEND: begin
        if (fall) begin
          if (r.bitCnt != 6'(sdcs_pkg::FRAME_BITS)) begin
            next_r.cmdOut = r.shift[47];
            next_r.cmdOe = r.od ? ~r.shift[47] : 1'b1;
            next_r.shift = {r.shift[46:0], 1'b0};
            next_r.bitCnt = r.bitCnt + 6'h01;
          end else begin
            next_r.cmdOe = 1'b0;
            next_r.cmdOut = 1'b1;
            if (r.phase2 && r.cmd.index == sdcs_pkg::CMD_IO_DATA) begin
              next_r.owner = {1'b0, r.arg[30:28]};
            end else if (r.phase2 &&
                         (r.cmd.index == sdcs_pkg::CMD_RD_SINGLE ||
                          r.cmd.index == sdcs_pkg::CMD_RD_MULTI ||
                          r.cmd.index == sdcs_pkg::CMD_WR_SINGLE ||
                          r.cmd.index == sdcs_pkg::CMD_WR_MULTI)) begin
              next_r.owner = sdcs_pkg::OWNER_MEM;
            end
            if (r.phase2 && r.cmd.app &&
                r.cmd.index == sdcs_pkg::CMD_SDSTAT) begin
              next_r.sdStart = 1'b1;
            end
            if (r.cmd.resp || !r.phase2) begin
              next_r.rxStart = 1'b1;
              next_r.fsm = sdcs_pkg::S_RESP;
            end else begin
              next_r.fsm = sdcs_pkg::S_IDLE;
            end
          end
        end
      end
      sdcs_pkg::S_RESP: begin
        if (respTimeout) begin
          next_r.timeout = 1'b1;
          next_r.fsm = sdcs_pkg::S_IDLE;
        end else if (respDone) begin
          // state field is that at receipt of this command
          next_r.cardStatus = respStatus;
          if (!respCrcOk) begin
            next_r.crcErr = 1'b1;
          end
          if (!r.phase2) begin
            if (respStatus[sdcs_pkg::CS_APP]) begin
              next_r.phase2 = 1'b1;
              next_r.shift = sdcs_pkg::sdcs_frame(r.cmd.index, r.arg);
              next_r.bitCnt = 6'h00;
              next_r.fsm = sdcs_pkg::S_SEND;
            end else begin
              next_r.refused = 1'b1;
              next_r.fsm = sdcs_pkg::S_IDLE;
            end
          end else if (r.cmd.index == sdcs_pkg::CMD_GEN) begin
            next_r.fsm = sdcs_pkg::S_BUSY;
          end else if (r.cmd.app && r.cmd.index == sdcs_pkg::CMD_SDSTAT) begin
            next_r.fsm = sdcs_pkg::S_DATA;
          end else begin
            next_r.fsm = sdcs_pkg::S_IDLE;
          end
        end
      end
      sdcs_pkg::S_BUSY: begin
        if (rise && r.sync2.dat[0]) begin
          next_r.fsm = sdcs_pkg::S_IDLE;
        end
      end
      sdcs_pkg::S_DATA: begin
        if (sdDone) begin
          next_r.sdTop = sdTop;
          next_r.sdValid = 1'b1;
          next_r.fsm = sdcs_pkg::S_IDLE;
        end
      end
      default: begin
        next_r.fsm = sdcs_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
      r.fsm <= sdcs_pkg::S_IDLE;
      r.cmdOut <= 1'b1;
      r.slow <= 1'b1;
      r.od <= 1'b1;
      r.sync1 <= '1;
      r.sync2 <= '1;
      r.clkPrev <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = penable;
  assign pslverr = psel & penable & ~mapped;
  assign cmdOut = r.cmdOut;
  assign cmdOe = r.cmdOe;
  assign dat2Out = 1'b0;
  assign dat2Oe = r.dat2Oe;
  assign slowClk = r.slow;
  assign openDrain = r.od;

endmodule

/* tb/sdcs_host_props.sv */
// checker: bus and pin relations of the card host
`timescale 1ns/1ps
module sdcs_host_props (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cmdOut,
  input wire logic cmdOe,
  input wire logic dat2Out,
  input wire logic dat2Oe,
  input wire logic openDrain
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic acc;
  logic bad;
  assign acc = psel && penable;
  assign bad = paddr > 8'h24 || paddr[1:0] != 2'b00;
  a_ready_no_wait: assert property (acc |-> pready)
    else $error("pready low");
  a_unmapped_err: assert property (acc && bad |-> pslverr)
    else $error("no slave error");
  a_mapped_ok: assert property (acc && !bad |-> !pslverr)
    else $error("false slave error");
  a_unmapped_zero: assert property (
    acc && bad && !pwrite |-> prdata == 0)
    else $error("unmapped data");
  a_rdata_hold: assert property (
    !(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
  a_od_low_only: assert property (openDrain && cmdOe |-> !cmdOut)
    else $error("driven high");
  a_release_high: assert property (!cmdOe |-> cmdOut)
    else $error("idle level low");
  a_frame_end_bit: assert property (
    $fell(cmdOe) && !openDrain |-> $past(cmdOut))
    else $error("end bit low");
  a_rwait_low: assert property (dat2Oe |-> !dat2Out)
    else $error("read wait high");
  cover property (acc && bad);
  cover property (openDrain && cmdOe);
  cover property (dat2Oe);
endmodule
bind sdcs_host sdcs_host_props sdcs_host_props_i (.mclk(mclk),
  .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cmdOut(cmdOut), .cmdOe(cmdOe), .dat2Out(dat2Out), .dat2Oe(dat2Oe),
  .openDrain(openDrain));

/* tb/sdcs_card_model.sv */
// model: card answering commands with R1 status frames
`timescale 1ns/1ps
module sdcs_card_model (
  input wire logic cardClk,
  input wire logic cmdLine,
  input wire logic irqReq,
  input wire logic errSet,
  output logic cmdOut = 1'b1,
  output logic cmdOe = 1'b0,
  output logic [3:0] dat
);
  logic [47:0] rx = 48'h0, tx = 48'h0;
  logic [31:0] cs;
  logic [5:0] i;
  logic [3:0] st = 4'h0;
  logic nxt = 1'b0, err = 1'b0, app, sd = 1'b0, d0 = 1'b1;
  logic [63:0] sds = 64'h0000_0000_0000_1234;
  int n = 0, busy = 0, ds = 0;
  assign dat = {2'b11, ~irqReq, d0};
  always @(posedge cardClk) begin
    if (errSet) err = 1'b1;
    if (busy == 0 && (n != 0 || cmdLine == 1'b0)) begin
      rx = {rx[46:0], cmdLine};
      n++;
      if (n == 48) begin
        n = 0;
        i = rx[45:40];
        app = i == 6'h37 || nxt && (i == 6'h0d || i == 6'h29);
        sd = app && i == 6'h0d;
        // errSet drives status bits 19..17 and 15..13; bit 22 is set by command 3f alone
        cs = {12'h0, {3{err}}, 1'b0, {3{err}}, st, 1'b1, 2'b00, app,
              5'h0};
        cs[22] = i == 6'h3f;
        nxt = i == 6'h37;
        if (i != 6'h00) begin
          err = 1'b0;
          tx = {2'b00, i, cs, sdcs_pkg::sdcs_crc7({2'b00, i, cs}), 1'b1};
          busy = 51;
        end
        // new state shows only in the next response
        if (i == 6'h00 || i == 6'h02 || i == 6'h03) begin
          st = {2'b00, i[1:0]};
        end
        if (i == 6'h07) st = 4'h4;
      end
    end
  end
  always @(negedge cardClk) begin
    if (ds > 0) ds--;
    // status block: idle, start, 512 data, 16 crc, end bit on data line 0
    if (busy == 1 && sd) ds = 531;
    if (busy > 0) busy--;
    d0 <= ds < 2 || ds > 530 || (ds >= 466 && ds < 530 && sds[ds - 466]);
    cmdOe <= busy > 0 && busy <= 48;
    cmdOut <= busy > 0 && busy <= 48 ? tx[busy - 1] : 1'b1;
  end
endmodule

/* tb/tb_top.sv */
// bench: drives the card host over APB against a card model
`timescale 1ns/1ps
module tb_top;
  logic mclk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, cardClk = 1'b0, irqReq = 1'b0, errSet = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, st;
  logic pready, pslverr, cmdOut, cmdOe, dat2Out, dat2Oe, slowClk, openDrain;
  logic cOut, cOe, err, od;
  logic [3:0] dat;
  int error_cnt = 0, num_checks = 0, cyc = 0;
  wire cmdLine = cmdOe ? cmdOut : (cOe ? cOut : 1'b1);
  wire [3:0] datLine = {dat[3], dat2Oe ? dat2Out : dat[2], dat[1:0]};
  sdcs_host sdcs_host_i (.mclk(mclk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cardClk(cardClk),
    .cmdIn(cmdLine), .cmdOut(cmdOut), .cmdOe(cmdOe), .datIn(datLine),
    .dat2Out(dat2Out), .dat2Oe(dat2Oe), .slowClk(slowClk),
    .openDrain(openDrain));
  sdcs_card_model sdcs_card_model_i (.cardClk(cardClk), .cmdLine(cmdLine),
    .irqReq(irqReq), .errSet(errSet), .cmdOut(cOut), .cmdOe(cOe), .dat(dat));
  initial forever #5 mclk = ~mclk;
  initial begin
    #1.3;
    forever #62.5 cardClk = ~cardClk;
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(logic [5:0] i, logic app, logic [31:0] dec);
    apb(1'b1, sdcs_pkg::OFF_CMD, {23'h0, 1'b1, i != 6'h00, app, i});
    repeat (2) @(posedge mclk);
    od = openDrain;
    repeat (4000) begin
      apb(1'b0, sdcs_pkg::OFF_STAT, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    check("busy", rd[0], 1'b0);
    st = rd;
    if (i != 6'h00) check("flags", {st[3], st[1]}, 2'b00);
    apb(1'b0, sdcs_pkg::OFF_DEC, 32'h0);
    if (i != 6'h00) check("dec", rd & 32'h3fff, dec);
  endtask
  task automatic t_ident();
    cmd(6'h00, 1'b0, 32'h0);
    check("od", od, 1'b1);
    cmd(6'h02, 1'b0, 32'h800);
    cmd(6'h03, 1'b0, 32'h802);
    cmd(6'h07, 1'b0, 32'h803);
    check("od", od, 1'b0);
    apb(1'b0, 8'h28, 32'h0);
    check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
  endtask
  task automatic t_gen();
    cmd(6'h38, 1'b0, 32'h803);
    check("refused", st[2], 1'b1);
    apb(1'b1, sdcs_pkg::OFF_STAT, 32'h4);
    cmd(6'h0d, 1'b0, 32'h804);
    cmd(6'h38, 1'b0, 32'h804);
    check("accepted", st[2], 1'b0);
    cmd(6'h3f, 1'b0, 32'h814);
  endtask
  task automatic t_app();
    errSet <= 1'b1;
    repeat (30) @(posedge mclk);
    errSet <= 1'b0;
    cmd(6'h0d, 1'b0, 32'hff4);
    cmd(6'h29, 1'b1, 32'h1804);
    apb(1'b0, sdcs_pkg::OFF_CSTAT, 32'h0);
    check("cstat", rd, 32'h920);
  endtask
  task automatic t_sd();
    cmd(6'h0d, 1'b1, 32'h1804);
    check("sd valid", st[6], 1'b1);
    apb(1'b0, sdcs_pkg::OFF_SDBW, 32'h0);
    check("sd width", rd, 32'hc);
    apb(1'b0, sdcs_pkg::OFF_SDPROT, 32'h0);
    check("sd prot", rd, 32'h1234);
    apb(1'b1, sdcs_pkg::OFF_SUSP, 32'h10);
    apb(1'b0, sdcs_pkg::OFF_STAT, 32'h0);
    check("fn0 refused", rd[2], 1'b1);
  endtask
  task automatic t_irq(logic en);
    apb(1'b1, sdcs_pkg::OFF_MODE, {28'h0, en, 3'b000});
    irqReq <= 1'b1;
    repeat (40) @(posedge mclk);
    irqReq <= 1'b0;
    apb(1'b0, sdcs_pkg::OFF_STAT, 32'h0);
    check("irq", rd[4], en);
    apb(1'b1, sdcs_pkg::OFF_STAT, 32'h10);
    apb(1'b0, sdcs_pkg::OFF_STAT, 32'h0);
    check("irq clr", rd[4], 1'b0);
  endtask
  task automatic t_rwait(logic [31:0] m, logic exp);
    apb(1'b1, sdcs_pkg::OFF_MODE, m);
    repeat (3) @(posedge mclk);
    check("rwait", dat2Oe, exp);
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    repeat (4) @(posedge mclk);
    check("reset pins", {slowClk, openDrain, cmdOe, dat2Oe}, 4'hc);
    reset_n <= 1'b1;
    t_ident();
    t_gen();
    t_app();
    t_sd();
    t_irq(1'b1);
    t_irq(1'b0);
    t_rwait(32'h6, 1'b1);
    t_rwait(32'h4, 1'b0);
    end_of_test();
  end
endmodule
